/* File: ptid_pkg.sv */
/*
 Constants shared by the target image decoder: register offsets,
 field positions, encodings, synchroniser slots and the mask helper.
 Assumes a 32-bit register port addressed by byte offset.
*/
package ptid_pkg;

	// Register byte offsets
	localparam int PTID_ADDR_W = 12;
	localparam logic [11:0] PTID_OFF_IMG1_CTL = 12'h110;
	localparam logic [11:0] PTID_OFF_IMG1_ADD = 12'h114;
	localparam logic [11:0] PTID_OFF_ROM_CTL = 12'h13C;

	// Upper address lines that are compared and translated
	localparam int PTID_UP_LSB = 16;
	localparam int PTID_UP_W = 16;

	// Image 1 control field positions
	localparam int CTL_EN_BIT = 31;
	localparam int CTL_BS_LSB = 24;
	localparam int CTL_PREFETCH_READS_ON_BIT = 23;
	localparam int CTL_BURST_BIT = 22;
	localparam int CTL_FLIP_BIT = 20;
	localparam int CTL_TC_LSB = 12;
	localparam int CTL_DW_LSB = 10;
	localparam int CTL_POSTED_WRITE_ALLOW_BIT = 7;
	localparam int CTL_SPACE_BIT = 6;

	// Image 1 address field positions
	localparam int ADD_BA_LSB = 16;
	localparam int ADD_TA_LSB = 0;

	// Expansion ROM control field positions
	localparam int ROM_DW_LSB = 24;
	localparam int ROM_BS_LSB = 20;
	localparam int ROM_TC_LSB = 16;
	localparam int ROM_TA_LSB = 0;

	// Field widths
	localparam int BS_W = 4;
	localparam int ROM_BS_W = 3;
	localparam int TC_W = 4;
	localparam int DW_W = 2;

	// Destination width encodings
	localparam logic [1:0] DW_32BIT = 2'h0;
	localparam logic [1:0] DW_8BIT = 2'h1;
	localparam logic [1:0] DW_16BIT = 2'h2;
	localparam logic [1:0] DW_RESERVED = 2'h3;

	// Address space encodings
	localparam logic SPACE_MEM = 1'b0;
	localparam logic SPACE_IO = 1'b1;

	// Pin synchroniser slots
	localparam int SYNC_PCI_RST_N = 0;
	localparam int SYNC_HOLD = 1;
	localparam int SYNC_EEPROM_LOAD_STRAP = 2;
	localparam int SYNC_SDA = 3;
	localparam int SYNC_W = 4;

	// Transaction hold states
	typedef enum logic [1:0] {TXN_IDLE, TXN_IMG, TXN_ROM} ptid_txn_t;

	// Compared lines: bit i stands for line 16+i, compared when i >= code
	function automatic logic [15:0] ptid_cmp_mask(input logic [3:0] code);
		ptid_cmp_mask = 16'hFFFF << code;
	endfunction

endpackage

/* File: ptid_match.sv */
/*
 Window compare and upper-line substitution for one decode image.
 Assumes the size code is already zero-extended to four bits.
*/
module ptid_match
(
	input wire logic [3:0] size_code_in,
	input wire logic [15:0] base_in,
	input wire logic [15:0] subst_in,
	input wire logic [31:0] addr_in,
	output logic hit_out,
	output logic [31:0] addr_out
);

	logic [15:0] mask; // Lines taking part in the compare
	logic [15:0] upper; // Incoming upper lines

	// Purely combinational; the caller registers the results
	always_comb
	begin
		mask = ptid_pkg::ptid_cmp_mask(size_code_in);
		upper = addr_in[ptid_pkg::PTID_UP_LSB +: ptid_pkg::PTID_UP_W];
		hit_out = (((upper ^ base_in) & mask) == 16'h0000);
		// Compared lines replaced, lower lines passed through
		addr_out = {(subst_in & mask) | (upper & ~mask),
			addr_in[ptid_pkg::PTID_UP_LSB-1:0]};
	end

endmodule

/* File: ptid_decode.sv */
/*
 Decode and translation for PCI target image 1 and the expansion ROM
 image, with their control and address registers.
 Assumes an EEPROM loader on the same clock that pulses its done strobe
 after the PCI reset ends, a configuration block that supplies the
 image 1 and ROM base registers, and PCI phase strobes on this clock.
*/
module ptid_decode
(
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	// Pins, asynchronous to the core clock
	input wire logic pci_rst_n_in,
	input wire logic host_config_hold_strap_in,
	input wire logic eeprom_load_strap_in,
	input wire logic eeprom_sda_in,
	// EEPROM loader results
	input wire logic ee_load_done_in,
	input wire logic ee_byte5_bit7_in,
	input wire logic ee_byte9_bit7_in,
	input wire logic [3:0] ee_window_size_code_in,
	input wire logic [31:0] ee_rom_ctl_in,
	// Configuration space
	input wire logic [15:0] img1_cfg_base_in,
	input wire logic img1_cfg_space_in,
	input wire logic [15:0] rom_base_in,
	input wire logic rom_decode_on_in,
	// Global byte order
	input wire logic local_byte_order_setting_in,
	// Register port
	input wire logic [11:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [31:0] reg_wdata_in,
	output logic [31:0] reg_rdata_out,
	output logic img1_cfg_base_on_out,
	// PCI target side
	input wire logic pci_addr_phase_in,
	input wire logic [31:0] pci_addr_in,
	input wire logic pci_io_cmd_in,
	input wire logic pci_write_in,
	input wire logic pci_txn_end_in,
	// Decode results, held for the transaction
	output logic img_hit_out,
	output logic rom_hit_out,
	output logic [31:0] local_addr_out,
	output logic [3:0] user_cycle_code_out,
	output logic [1:0] destination_width_out,
	output logic byte_order_out,
	output logic prefetch_ok_out,
	output logic burst_write_ok_out,
	output logic posted_write_ok_out
);

	// Pin synchroniser stages and filtered values
	logic [3:0] sync1_reg; // First stage, read only by the second
	logic [3:0] sync2_reg;
	logic [3:0] sync3_reg;
	logic [3:0] pin_reg; // Value once stages two and three agree
	logic pci_rst_act; // PCI bus reset held

	// Straps caught while the PCI reset is held
	logic hold_strap_reg;
	logic eeprom_load_strap_reg;
	logic sda_reg;

	// EEPROM preload status
	logic img1_loaded_reg; // Size came from EEPROM, space from the config base
	logic rom_loaded_reg; // ROM control came from EEPROM

	// Image 1 control fields
	logic image_on_reg;
	logic [3:0] window_size_code_reg;
	logic prefetch_reads_on_reg;
	logic burst_write_allow_reg;
	logic flip_byte_order_reg;
	logic [3:0] user_cycle_code_reg;
	logic [1:0] destination_width_reg;
	logic posted_write_allow_reg;
	logic target_space_select_reg;

	// Image 1 address fields
	logic [15:0] match_bits_reg;
	logic [15:0] substitute_bits_reg;

	// Expansion ROM control fields
	logic [1:0] rom_width_reg;
	logic [2:0] rom_size_reg;
	logic [3:0] rom_code_reg;
	logic [15:0] rom_subst_reg;

	// Effective values after mirroring
	logic size_space_wr_ok; // Size and space may be written
	logic match_mirror; // Match bits follow the config base
	logic [15:0] match_eff;
	logic space_eff;
	logic rom_load_ok;

	// Write strobes
	logic wr_ctl;
	logic wr_add;
	logic wr_rom;

	// Compare results
	logic img_match;
	logic rom_match;
	logic [31:0] img_addr;
	logic [31:0] rom_addr;
	logic img_claim;
	logic rom_claim;

	// Transaction hold
	ptid_pkg::ptid_txn_t txn_reg;

	// Three-stage pin synchroniser; a change passes once stages agree
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			sync1_reg <= 4'h0;
			sync2_reg <= 4'h0;
			sync3_reg <= 4'h0;
			pin_reg <= 4'h0;
		end
		else
		begin
			sync1_reg <= {eeprom_sda_in, eeprom_load_strap_in,
				host_config_hold_strap_in, pci_rst_n_in};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			// Bits that disagree keep their last settled value
			pin_reg <= (sync2_reg & ~(sync2_reg ^ sync3_reg))
				| (pin_reg & (sync2_reg ^ sync3_reg));
		end
	end

	// Reset reads as active until the pin settles high
	assign pci_rst_act = ~pin_reg[ptid_pkg::SYNC_PCI_RST_N];

	// Straps track the pins during PCI reset and freeze at release
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			hold_strap_reg <= 1'b0;
			eeprom_load_strap_reg <= 1'b0;
			sda_reg <= 1'b0;
		end
		else if (pci_rst_act)
		begin
			hold_strap_reg <= pin_reg[ptid_pkg::SYNC_HOLD];
			eeprom_load_strap_reg <= pin_reg[ptid_pkg::SYNC_EEPROM_LOAD_STRAP];
			sda_reg <= pin_reg[ptid_pkg::SYNC_SDA];
		end
	end

	// Mirror and write-permission decisions
	assign size_space_wr_ok = ~img1_loaded_reg | hold_strap_reg;
	assign match_mirror = img1_loaded_reg | hold_strap_reg;
	assign match_eff = match_mirror ? img1_cfg_base_in : match_bits_reg;
	// Loaded space bit follows the config base unless strap overrides
	assign space_eff = (img1_loaded_reg & ~hold_strap_reg)
		? img1_cfg_space_in : target_space_select_reg;
	assign img1_cfg_base_on_out = match_mirror;
	assign rom_load_ok = (sda_reg | eeprom_load_strap_reg) & ee_byte5_bit7_in;

	// Register write strobes
	assign wr_ctl = reg_wr_in && (reg_addr_in == ptid_pkg::PTID_OFF_IMG1_CTL);
	assign wr_add = reg_wr_in && (reg_addr_in == ptid_pkg::PTID_OFF_IMG1_ADD);
	assign wr_rom = reg_wr_in && (reg_addr_in == ptid_pkg::PTID_OFF_ROM_CTL);

	// Preload status: cleared by PCI reset, set by the loader strobe
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			img1_loaded_reg <= 1'b0;
			rom_loaded_reg <= 1'b0;
		end
		else if (pci_rst_act)
		begin
			img1_loaded_reg <= 1'b0;
			rom_loaded_reg <= 1'b0;
		end
		else if (ee_load_done_in)
		begin
			img1_loaded_reg <= ee_byte9_bit7_in;
			rom_loaded_reg <= rom_load_ok;
		end
	end

	// General-reset control fields of image 1
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			image_on_reg <= 1'b0;
			prefetch_reads_on_reg <= 1'b0;
			burst_write_allow_reg <= 1'b0;
			flip_byte_order_reg <= 1'b0;
			user_cycle_code_reg <= 4'h0;
			destination_width_reg <= ptid_pkg::DW_32BIT;
			posted_write_allow_reg <= 1'b0;
		end
		else if (wr_ctl)
		begin
			image_on_reg <= reg_wdata_in[ptid_pkg::CTL_EN_BIT];
			prefetch_reads_on_reg <= reg_wdata_in[ptid_pkg::CTL_PREFETCH_READS_ON_BIT];
			burst_write_allow_reg <= reg_wdata_in[ptid_pkg::CTL_BURST_BIT];
			flip_byte_order_reg <= reg_wdata_in[ptid_pkg::CTL_FLIP_BIT];
			user_cycle_code_reg <=
				reg_wdata_in[ptid_pkg::CTL_TC_LSB +: ptid_pkg::TC_W];
			// Reserved code 11b is stored as written; software avoids it
			destination_width_reg <=
				reg_wdata_in[ptid_pkg::CTL_DW_LSB +: ptid_pkg::DW_W];
			posted_write_allow_reg <= reg_wdata_in[ptid_pkg::CTL_POSTED_WRITE_ALLOW_BIT];
		end
	end

	// PCI-reset size and space fields, preloadable from EEPROM
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			window_size_code_reg <= 4'h0;
			target_space_select_reg <= ptid_pkg::SPACE_MEM;
		end
		else if (pci_rst_act)
		begin
			window_size_code_reg <= 4'h0;
			target_space_select_reg <= ptid_pkg::SPACE_MEM;
		end
		else if (ee_load_done_in && ee_byte9_bit7_in)
		begin
			// Size comes from EEPROM; space is copied from the config base and stored
			window_size_code_reg <= ee_window_size_code_in;
			target_space_select_reg <= img1_cfg_space_in;
		end
		else if (wr_ctl && size_space_wr_ok)
		begin
			window_size_code_reg <=
				reg_wdata_in[ptid_pkg::CTL_BS_LSB +: ptid_pkg::BS_W];
			target_space_select_reg <= reg_wdata_in[ptid_pkg::CTL_SPACE_BIT];
		end
	end

	// Match bits: PCI reset clears, writes only when not mirrored
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			match_bits_reg <= 16'h0000;
		else if (pci_rst_act)
			match_bits_reg <= 16'h0000;
		else if (wr_add && !match_mirror)
			match_bits_reg <=
				reg_wdata_in[ptid_pkg::ADD_BA_LSB +: ptid_pkg::PTID_UP_W];
	end

	// Substitute bits: general reset only, EEPROM has no say
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			substitute_bits_reg <= 16'h0000;
		else if (wr_add)
			substitute_bits_reg <=
				reg_wdata_in[ptid_pkg::ADD_TA_LSB +: ptid_pkg::PTID_UP_W];
	end

	// Expansion ROM control: zero and locked unless EEPROM loaded it
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			rom_width_reg <= ptid_pkg::DW_32BIT;
			rom_size_reg <= 3'h0;
			rom_code_reg <= 4'h0;
			rom_subst_reg <= 16'h0000;
		end
		else if (pci_rst_act)
		begin
			rom_width_reg <= ptid_pkg::DW_32BIT;
			rom_size_reg <= 3'h0;
			rom_code_reg <= 4'h0;
			rom_subst_reg <= 16'h0000;
		end
		else if (ee_load_done_in && rom_load_ok)
		begin
			rom_width_reg <= ee_rom_ctl_in[ptid_pkg::ROM_DW_LSB +: ptid_pkg::DW_W];
			rom_size_reg <=
				ee_rom_ctl_in[ptid_pkg::ROM_BS_LSB +: ptid_pkg::ROM_BS_W];
			rom_code_reg <= ee_rom_ctl_in[ptid_pkg::ROM_TC_LSB +: ptid_pkg::TC_W];
			rom_subst_reg <=
				ee_rom_ctl_in[ptid_pkg::ROM_TA_LSB +: ptid_pkg::PTID_UP_W];
		end
		else if (wr_rom && rom_loaded_reg)
		begin
			// Writes are ignored while the register stays unloaded
			rom_width_reg <= reg_wdata_in[ptid_pkg::ROM_DW_LSB +: ptid_pkg::DW_W];
			rom_size_reg <=
				reg_wdata_in[ptid_pkg::ROM_BS_LSB +: ptid_pkg::ROM_BS_W];
			rom_code_reg <= reg_wdata_in[ptid_pkg::ROM_TC_LSB +: ptid_pkg::TC_W];
			rom_subst_reg <=
				reg_wdata_in[ptid_pkg::ROM_TA_LSB +: ptid_pkg::PTID_UP_W];
		end
	end

	// Registered read port; unmapped offsets return zero
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			reg_rdata_out <= 32'h0000_0000;
		else if (reg_rd_in)
		begin
			reg_rdata_out <= 32'h0000_0000;
			case (reg_addr_in)
				ptid_pkg::PTID_OFF_IMG1_CTL:
				begin
					reg_rdata_out[ptid_pkg::CTL_EN_BIT] <= image_on_reg;
					reg_rdata_out[ptid_pkg::CTL_BS_LSB +: ptid_pkg::BS_W] <=
						window_size_code_reg;
					reg_rdata_out[ptid_pkg::CTL_PREFETCH_READS_ON_BIT] <= prefetch_reads_on_reg;
					reg_rdata_out[ptid_pkg::CTL_BURST_BIT] <= burst_write_allow_reg;
					reg_rdata_out[ptid_pkg::CTL_FLIP_BIT] <= flip_byte_order_reg;
					reg_rdata_out[ptid_pkg::CTL_TC_LSB +: ptid_pkg::TC_W] <=
						user_cycle_code_reg;
					reg_rdata_out[ptid_pkg::CTL_DW_LSB +: ptid_pkg::DW_W] <=
						destination_width_reg;
					reg_rdata_out[ptid_pkg::CTL_POSTED_WRITE_ALLOW_BIT] <= posted_write_allow_reg;
					reg_rdata_out[ptid_pkg::CTL_SPACE_BIT] <= space_eff;
				end
				ptid_pkg::PTID_OFF_IMG1_ADD:
				begin
					reg_rdata_out[ptid_pkg::ADD_BA_LSB +: ptid_pkg::PTID_UP_W] <=
						match_eff;
					reg_rdata_out[ptid_pkg::ADD_TA_LSB +: ptid_pkg::PTID_UP_W] <=
						substitute_bits_reg;
				end
				ptid_pkg::PTID_OFF_ROM_CTL:
				begin
					reg_rdata_out[ptid_pkg::ROM_DW_LSB +: ptid_pkg::DW_W] <=
						rom_width_reg;
					reg_rdata_out[ptid_pkg::ROM_BS_LSB +: ptid_pkg::ROM_BS_W] <=
						rom_size_reg;
					reg_rdata_out[ptid_pkg::ROM_TC_LSB +: ptid_pkg::TC_W] <=
						rom_code_reg;
					reg_rdata_out[ptid_pkg::ROM_TA_LSB +: ptid_pkg::PTID_UP_W] <=
						rom_subst_reg;
				end
				default:
					reg_rdata_out <= 32'h0000_0000;
			endcase
		end
	end

	// Image 1 window compare and translation
	ptid_match u_img_match
	(
		.size_code_in(window_size_code_reg),
		.base_in(match_eff),
		.subst_in(substitute_bits_reg),
		.addr_in(pci_addr_in),
		.hit_out(img_match),
		.addr_out(img_addr)
	);

	// ROM window compare: three-bit code, 64 Kbyte to 8 Mbyte
	ptid_match u_rom_match
	(
		.size_code_in({1'b0, rom_size_reg}),
		.base_in(rom_base_in),
		.subst_in(rom_subst_reg),
		.addr_in(pci_addr_in),
		.hit_out(rom_match),
		.addr_out(rom_addr)
	);

	// Claim decisions; image 1 wins if both windows overlap
	assign img_claim = image_on_reg && (pci_io_cmd_in == space_eff)
		&& img_match;
	assign rom_claim = rom_decode_on_in && !pci_io_cmd_in && rom_match
		&& !img_claim;

	// Transaction state: claimed at address phase, held until end
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			txn_reg <= ptid_pkg::TXN_IDLE;
		else
		begin
			case (txn_reg)
				ptid_pkg::TXN_IDLE:
					if (pci_addr_phase_in && img_claim)
						txn_reg <= ptid_pkg::TXN_IMG;
					else if (pci_addr_phase_in && rom_claim)
						txn_reg <= ptid_pkg::TXN_ROM;
				ptid_pkg::TXN_IMG, ptid_pkg::TXN_ROM:
					if (pci_txn_end_in)
						txn_reg <= ptid_pkg::TXN_IDLE;
				default:
					txn_reg <= ptid_pkg::TXN_IDLE;
			endcase
		end
	end

	// Attribute capture; a later register write leaves the transfer alone
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			local_addr_out <= 32'h0000_0000;
			user_cycle_code_out <= 4'h0;
			destination_width_out <= ptid_pkg::DW_32BIT;
			byte_order_out <= 1'b0;
			prefetch_ok_out <= 1'b0;
			burst_write_ok_out <= 1'b0;
			posted_write_ok_out <= 1'b0;
		end
		else if (txn_reg == ptid_pkg::TXN_IDLE && pci_addr_phase_in)
		begin
			if (img_claim)
			begin
				local_addr_out <= img_addr;
				user_cycle_code_out <= user_cycle_code_reg;
				destination_width_out <= destination_width_reg;
				byte_order_out <= local_byte_order_setting_in
					^ flip_byte_order_reg;
				prefetch_ok_out <= prefetch_reads_on_reg && !pci_write_in;
				burst_write_ok_out <= burst_write_allow_reg && pci_write_in;
				// I/O space writes are never posted
				posted_write_ok_out <= posted_write_allow_reg && pci_write_in
					&& (space_eff == ptid_pkg::SPACE_MEM);
			end
			else if (rom_claim)
			begin
				local_addr_out <= rom_addr;
				user_cycle_code_out <= rom_code_reg;
				destination_width_out <= rom_width_reg;
				byte_order_out <= local_byte_order_setting_in;
				prefetch_ok_out <= 1'b0;
				burst_write_ok_out <= 1'b0;
				posted_write_ok_out <= 1'b0;
			end
		end
	end

	// Hit levels follow the hold state; space bit picks the command type
	assign img_hit_out = (txn_reg == ptid_pkg::TXN_IMG);
	assign rom_hit_out = (txn_reg == ptid_pkg::TXN_ROM);

endmodule

/* File: ptid_decode_checker.sv */
/*
 Port checker for the image decoder: hit lifetime, held attributes
 and the gating of prefetch, burst and posting.
 Assumes it is bound onto the decoder top and sees only its ports.
*/
module ptid_decode_checker
(
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic pci_addr_phase_in,
	input wire logic [31:0] pci_addr_in,
	input wire logic pci_io_cmd_in,
	input wire logic pci_write_in,
	input wire logic pci_txn_end_in,
	input wire logic img_hit_out,
	input wire logic rom_hit_out,
	input wire logic [31:0] local_addr_out,
	input wire logic [3:0] user_cycle_code_out,
	input wire logic prefetch_ok_out,
	input wire logic burst_write_ok_out,
	input wire logic posted_write_ok_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	// Address phase offered while nothing is held
	sequence claim_s;
		pci_addr_phase_in && !img_hit_out && !rom_hit_out;
	endsequence
	// Offered phase answered by a hit one cycle later
	sequence won_s;
		claim_s ##1 (img_hit_out || rom_hit_out);
	endsequence
	single_hit_a: assert property (!(img_hit_out && rom_hit_out))
		else $error("both images claim one transaction");
	hit_hold_a: assert property (img_hit_out && !pci_txn_end_in |=>
		img_hit_out) else $error("image hit dropped early");
	hit_end_a: assert property (pci_txn_end_in |=>
		!img_hit_out && !rom_hit_out) else $error("hit outlived end");
	hit_cause_a: assert property ($rose(img_hit_out) |->
		$past(pci_addr_phase_in)) else $error("hit without phase");
	// A register write mid transfer must not reach the held outputs
	attr_stable_a: assert property (!pci_addr_phase_in |=>
		$stable(local_addr_out) && $stable(user_cycle_code_out))
		else $error("attributes moved without claim");
	low_pass_a: assert property (won_s |->
		local_addr_out[15:0] == $past(pci_addr_in[15:0]))
		else $error("lower lines altered");
	io_unposted_a: assert property (pci_io_cmd_in ##0 won_s |->
		!posted_write_ok_out) else $error("io write posted");
	read_noburst_a: assert property (!pci_write_in ##0 won_s |->
		!burst_write_ok_out) else $error("read allowed burst write");
	write_nopref_a: assert property (pci_write_in ##0 won_s |->
		!prefetch_ok_out) else $error("write allowed prefetch");
	rom_plain_a: assert property (rom_hit_out |-> !posted_write_ok_out
		&& !prefetch_ok_out) else $error("rom access posted");
endmodule

/* File: ptid_pci_master_model.sv */
/*
 Behavioural PCI master driving the decoder's target side.
 Assumes the bench asks for a phase or an end one clock ahead.
*/
module ptid_pci_master_model
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic start_in,
	input wire logic finish_in,
	input wire logic [31:0] addr_in,
	input wire logic io_in,
	input wire logic wr_in,
	output logic phase_out,
	output logic end_out,
	output logic [31:0] ad_out,
	output logic io_out,
	output logic wr_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// One-cycle phase and end pulses; outside a phase the lines are
	// released, so they toggle and a stale address never looks valid
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			phase_out <= 1'b0;
			end_out <= 1'b0;
			ad_out <= 32'h0;
			io_out <= 1'b0;
			wr_out <= 1'b0;
		end
		else
		begin
			phase_out <= start_in;
			end_out <= finish_in & ~start_in;
			ad_out <= start_in ? addr_in : ~ad_out;
			io_out <= start_in ? io_in : ~io_out;
			wr_out <= start_in ? wr_in : ~wr_out;
		end
	end
endmodule

/* File: ptid_decode_tb.sv */
/*
 Bench for the image decoder: registers, window decode, attributes,
 preload and strap cases, expansion ROM decode.
 Assumes the decoder, checker and master model are compiled first.
*/
module ptid_decode_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic pci_rst_n_in = 1'b0;
	logic hold = 1'b0;
	logic sda = 1'b0;
	logic done = 1'b0;
	logic b5 = 1'b0;
	logic b9 = 1'b0;
	logic eeprom_load_strap = 1'b0;
	logic bo = 1'b1;
	logic rom_on = 1'b1;
	logic [11:0] ra = 12'h000;
	logic rw = 1'b0;
	logic rr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdata;
	logic [31:0] la;
	logic img_hit;
	logic rom_hit;
	logic base_on;
	logic [9:0] attr;
	// Requests to the master model and what it drives
	logic start = 1'b0;
	logic fin = 1'b0;
	logic io = 1'b0;
	logic wr = 1'b0;
	logic [31:0] addr = 32'h0;
	logic ph;
	logic pe;
	logic pio;
	logic pwr;
	logic [31:0] pad;
	logic [15:0] m;
	logic [31:0] a;
	int fails = 0;
	int checks_done = 0;
	// Five loader and config inputs tied: the load word carries junk
	// in reserved bits so the read-back proves they are dropped
	ptid_decode ptid_decode_inst (.core_clk_in, .rst_n_in, .pci_rst_n_in,
		.host_config_hold_strap_in(hold), .eeprom_load_strap_in(eeprom_load_strap),
		.eeprom_sda_in(sda), .ee_load_done_in(done),
		.ee_byte5_bit7_in(b5), .ee_byte9_bit7_in(b9),
		.ee_window_size_code_in(4'h3), .ee_rom_ctl_in(32'hF1A5ABCD),
		.img1_cfg_base_in(16'h5A00), .img1_cfg_space_in(1'b1),
		.rom_base_in(16'h7788), .rom_decode_on_in(rom_on),
		.local_byte_order_setting_in(bo), .reg_addr_in(ra),
		.reg_wr_in(rw), .reg_rd_in(rr), .reg_wdata_in(wd),
		.reg_rdata_out(rdata), .img1_cfg_base_on_out(base_on),
		.pci_addr_phase_in(ph), .pci_addr_in(pad), .pci_io_cmd_in(pio),
		.pci_write_in(pwr), .pci_txn_end_in(pe), .img_hit_out(img_hit),
		.rom_hit_out(rom_hit), .local_addr_out(la),
		.user_cycle_code_out(attr[3:0]), .destination_width_out(attr[5:4]),
		.byte_order_out(attr[6]), .prefetch_ok_out(attr[9]),
		.burst_write_ok_out(attr[8]), .posted_write_ok_out(attr[7]));
	ptid_pci_master_model ptid_pci_master_model_inst (.clk_in(core_clk_in),
		.rst_n_in, .start_in(start), .finish_in(fin), .addr_in(addr),
		.io_in(io), .wr_in(wr), .phase_out(ph), .end_out(pe), .ad_out(pad),
		.io_out(pio), .wr_out(pwr));
	// 125 MHz clock
	initial
	begin
		forever #4 core_clk_in = ~core_clk_in;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [11:0] ad, input logic [31:0] d);
		@(posedge core_clk_in);
		ra <= ad;
		wd <= d;
		rw <= 1'b1;
		@(posedge core_clk_in);
		rw <= 1'b0;
	endtask
	// Data lands at the edge after the read is taken
	task automatic rreg(input logic [11:0] ad, input logic [31:0] exp);
		@(posedge core_clk_in);
		ra <= ad;
		rr <= 1'b1;
		@(posedge core_clk_in);
		rr <= 1'b0;
		#1 chk(rdata, exp);
	endtask
	// Model puts the phase out one edge later; hits show one after that
	task automatic txn(input logic [31:0] ad, input logic i, input logic w,
		input logic [1:0] exp);
		@(posedge core_clk_in);
		addr <= ad;
		io <= i;
		wr <= w;
		start <= 1'b1;
		@(posedge core_clk_in);
		start <= 1'b0;
		@(posedge core_clk_in);
		#1 chk(32'({img_hit, rom_hit}), 32'(exp));
	endtask
	task automatic fin_txn;
		@(posedge core_clk_in);
		fin <= 1'b1;
		@(posedge core_clk_in);
		fin <= 1'b0;
		@(posedge core_clk_in);
		#1 chk(32'({img_hit, rom_hit}), 32'h0);
	endtask
	task automatic go(input logic [31:0] ad, input logic i, input logic w,
		input logic [1:0] exp);
		txn(ad, i, w, exp);
		fin_txn();
	endtask
	// Both resets low 16 cycles; PCI reset ends later, then the loader
	task automatic do_reset(input logic p5, input logic p9, input logic hs);
		@(posedge core_clk_in);
		rst_n_in <= 1'b0;
		pci_rst_n_in <= 1'b0;
		b5 <= p5;
		b9 <= p9;
		// With the hold strap up, the load strap carries the ROM preload
		sda <= p5 & ~hs;
		eeprom_load_strap <= p5 & hs;
		hold <= hs;
		repeat (16) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		repeat (4) @(posedge core_clk_in);
		pci_rst_n_in <= 1'b1;
		repeat (8) @(posedge core_clk_in);
		done <= 1'b1;
		@(posedge core_clk_in);
		done <= 1'b0;
		repeat (2) @(posedge core_clk_in);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Main sequence: no preload, then preload, then hold strap
	initial
	begin
		do_reset(1'b0, 1'b0, 1'b0);
		rreg(12'h110, 32'h0);
		rreg(12'h114, 32'h0);
		chk(32'(base_on), 32'h0);
		wreg(12'h13C, 32'hFFFFFFFF);
		rreg(12'h13C, 32'h0);
		wreg(12'h118, 32'hFFFFFFFF);
		rreg(12'h118, 32'h0);
		wreg(12'h110, 32'hFFFFFFFF);
		rreg(12'h110, 32'h8FD0FCC0);
		wreg(12'h114, 32'hA5C31234);
		rreg(12'h114, 32'hA5C31234);
		// Every size code; uncompared upper lines differ from the base
		for (int c = 0; c < 16; c++)
		begin
			m = 16'hFFFF << c;
			a = {(16'hA5C3 & m) | (16'h5A3C & ~m), 16'h5678};
			wreg(12'h110, 32'h80000000 | (32'(c) << 24) | (32'(c) << 12)
				| (32'(c % 3) << 10));
			go(a, 1'b0, 1'b0, 2'b10);
			chk(la, {(16'h1234 & m) | (a[31:16] & ~m), 16'h5678});
			chk(32'(attr[5:0]), 32'(c % 3) * 16 + 32'(c));
			go(a ^ (32'h1 << (16 + c)), 1'b0, 1'b0, 2'b00);
		end
		wreg(12'h110, 32'h00000000);
		go(32'hA5C30010, 1'b0, 1'b0, 2'b00);
		wreg(12'h110, 32'h80D0A880);
		txn(32'hA5C30010, 1'b0, 1'b0, 2'b10);
		wreg(12'h110, 32'h80000000);
		fin_txn();
		chk(32'(attr), 32'h22A);
		go(32'hA5C30010, 1'b0, 1'b1, 2'b10);
		chk(32'(attr), 32'h040);
		wreg(12'h110, 32'h80D0A880);
		go(32'hA5C30010, 1'b0, 1'b1, 2'b10);
		chk(32'(attr), 32'h1AA);
		go(32'hA5C30010, 1'b1, 1'b1, 2'b00);
		wreg(12'h110, 32'h80D0A8C0);
		go(32'hA5C30010, 1'b1, 1'b1, 2'b10);
		chk(32'(attr), 32'h12A);
		go(32'hA5C30010, 1'b0, 1'b0, 2'b00);
		do_reset(1'b1, 1'b1, 1'b0);
		rreg(12'h13C, 32'h0125ABCD);
		chk(32'(base_on), 32'h1);
		wreg(12'h110, 32'h00000000);
		rreg(12'h110, 32'h03000040);
		wreg(12'h114, 32'hFFFF1111);
		rreg(12'h114, 32'h5A001111);
		go(32'h778B4321, 1'b0, 1'b0, 2'b01);
		chk(la, 32'hABCF4321);
		chk(32'(attr[5:0]), 32'h15);
		go(32'h778F4321, 1'b0, 1'b0, 2'b00);
		// ROM base register switched off: a matching address is ignored
		@(posedge core_clk_in) rom_on <= 1'b0;
		go(32'h778B4321, 1'b0, 1'b0, 2'b00);
		do_reset(1'b1, 1'b1, 1'b1);
		rreg(12'h13C, 32'h0125ABCD);
		wreg(12'h110, 32'h0A000000);
		rreg(12'h110, 32'h0A000000);
		rreg(12'h114, 32'h5A000000);
		// Untranslated window: substitute bits equal the match bits
		wreg(12'h110, 32'h80000000);
		wreg(12'h114, 32'h5A005A00);
		go(32'h5A001234, 1'b0, 1'b0, 2'b10);
		chk(la, 32'h5A001234);
		// Global order cleared with flip off: captured order follows it
		@(posedge core_clk_in) bo <= 1'b0;
		go(32'h5A001234, 1'b0, 1'b0, 2'b10);
		chk(32'(attr[6]), 32'h0);
		report_and_stop();
	end
	// Guard against a hang
	initial
	begin
		#500000;
		fails++;
		report_and_stop();
	end
endmodule
bind ptid_decode ptid_decode_checker ptid_decode_checker_inst (
	.core_clk_in, .rst_n_in, .pci_addr_phase_in, .pci_addr_in,
	.pci_io_cmd_in, .pci_write_in, .pci_txn_end_in, .img_hit_out,
	.rom_hit_out, .local_addr_out, .user_cycle_code_out, .prefetch_ok_out,
	.burst_write_ok_out, .posted_write_ok_out);
